/* File: logic/acsf_front_end.sv */
// command decode, register bank and status flags behind the serial port
// ****************************************************************
// How it works
// - command accepted only when bit 7 low
// - bit 6 picks read or write
// - bits 5..0 give the register index
// - low indices decode to fixed registers
// - 0x10..0x17 are channel registers
// - 0x20..0x27 are setup registers
// - 0x28..0x2f are filter registers
// - 0x30..0x37 are offset registers
// - 0x38..0x3f are gain registers
// - status 8 bits, reset 0x80, appendable
// - new result clears pending bit
// - calibration result clears pending bit
// - data register read sets pending bit
// - idle selected line shows pending bit
// - range fault flagged, result clamped
// - range fault updates only with results
// - bad write checksum sets checksum fault
// - status read clears checksum fault
// - watched registers changing set integrity fault
// - integrity fault clears with watch off
// - status low bits hold result channel
// ****************************************************************
`timescale 1ns/1ps
module acsf_front_end
    import acsf_pkg::*;
#(
    parameter logic [15:0] ID_VALUE   = 16'h0A5A,  // arbitrary value
    parameter logic [23:0] GAIN_RESET = 24'h50_0000
) (
    input  wire logic         ref_clk_i,
    input  wire logic         rst_b_i,
    input  wire logic         sclk_i,
    input  wire logic         cs_b_i,
    input  wire logic         sdi_i,
    input  wire acsf_result_t result_i,
    output logic              sdo_o,
    output logic              sdo_oe_o,
    output logic [15:0]       adc_mode_o
);

    // ************************************************************
    // state types
    // ************************************************************
    typedef logic [63:0][23:0] acsf_bank_t;

    typedef struct packed {
        acsf_state_t state;
        logic [2:0]  cnt;
        logic        crc_en;
        logic [5:0]  idx;
        logic [23:0] acc;
        logic [7:0]  crc;
        logic [23:0] rd_word;
        logic [7:0]  tx_byte;
        acsf_bank_t  regs;
        logic        pending;
        logic        range_fault;
        logic        cks_fault;
        logic        integ_fault;
        logic [2:0]  chan;
        logic [23:0] sig;
        logic        watch_d;
        logic        cs_s1;
        logic        cs_s2;
        logic        tgl_s1;
        logic        tgl_s2;
        logic        tgl_seen;
        logic        txb_s1;
        logic        txb_s2;
        logic        sdo;
        logic        sdo_oe;
    } acsf_core_t;

    typedef struct packed {
        logic [2:0] cnt;
        logic [6:0] sh;
    } acsf_frame_t;

    typedef struct packed {
        logic [7:0] data;
        logic       tgl;
    } acsf_rxbyte_t;

    typedef struct packed {
        logic [6:0] sh;
        logic       bit_v;
    } acsf_tx_t;

    // ************************************************************
    // functions
    // ************************************************************
    function automatic logic [7:0] crc8(input logic [7:0] c, input logic [7:0] d);
        logic [7:0] r;
        r = c ^ d;
        for (int i = 0; i < 8; i++) begin
            r = r[7] ? ((r << 1) ^ CRC_POLY) : (r << 1);
        end
        return r;
    endfunction

    function automatic logic [2:0] reg_bytes(input logic [5:0] ix, input logic app);
        logic [2:0] n;
        n = 3'h1;
        unique case (ix[5:3])
            3'h0: begin
                if (ix == IDX_ADC_MODE || ix == IDX_IF_MODE ||
                    ix == IDX_GPIO || ix == IDX_ID) begin
                    n = 3'h2;
                end else if (ix == IDX_REG_CHECK) begin
                    n = 3'h3;
                end else if (ix == IDX_DATA) begin
                    n = app ? 3'h4 : 3'h3;
                end
            end
            BANK_CHANNEL, BANK_SETUP, BANK_FILTER: n = 3'h2;
            BANK_OFFSET, BANK_GAIN:                 n = 3'h3;
            default:                                n = 3'h1;
        endcase
        return n;
    endfunction

    function automatic logic writable(input logic [5:0] ix);
        return (ix == IDX_ADC_MODE) || (ix == IDX_IF_MODE) || (ix == IDX_GPIO) ||
               (ix[5:3] == BANK_CHANNEL) || ix[5];
    endfunction

    // signature over the watched configuration registers
    function automatic logic [23:0] fold(input acsf_bank_t b);
        logic [23:0] f;
        f = 24'h00_0000;
        for (int i = 0; i < 64; i++) begin
            if (writable(6'(i)) && (6'(i) != IDX_IF_MODE)) begin
                f = {f[22:0], f[23]} ^ b[i];
            end
        end
        return f;
    endfunction

    function automatic acsf_core_t core_reset();
        acsf_core_t c;
        c = '0;
        c.state    = ST_IDLE;
        c.pending  = STATUS_RESET[ST_PENDING_BIT];
        c.cs_s1    = 1'b1;
        c.cs_s2    = 1'b1;
        c.regs[IDX_ADC_MODE] = RST_ADC_MODE;
        for (int i = 0; i < 8; i++) begin
            c.regs[32 + i] = RST_SETUP;
            c.regs[40 + i] = RST_FILTER;
            c.regs[48 + i] = RST_OFFSET;
            c.regs[56 + i] = GAIN_RESET;
        end
        return c;
    endfunction

    localparam acsf_core_t CORE_RST = core_reset();

    // ************************************************************
    // link side, on the serial clock
    // ************************************************************
    acsf_frame_t  frm_r;
    acsf_frame_t  frm_nxt;
    acsf_rxbyte_t rxb_r;
    acsf_rxbyte_t rxb_nxt;
    acsf_tx_t     tx_r;
    acsf_tx_t     tx_nxt;
    acsf_core_t   c_r;
    acsf_core_t   c_nxt;
    logic         frame_rst_b;

    // deselect ends the frame and realigns the bit counter
    assign frame_rst_b = rst_b_i & ~cs_b_i;

    always_comb begin
        frm_nxt     = frm_r;
        frm_nxt.cnt = frm_r.cnt + 3'h1;
        frm_nxt.sh  = {frm_r.sh[5:0], sdi_i};
        rxb_nxt     = rxb_r;
        if (frm_r.cnt == LAST_BIT) begin
            rxb_nxt.data = {frm_r.sh, sdi_i};
            rxb_nxt.tgl  = ~rxb_r.tgl;
        end
        tx_nxt = tx_r;
        if (frm_r.cnt == 3'h0) begin
            // tx_byte held stable by the core long before this edge
            tx_nxt.bit_v = c_r.tx_byte[7];
            tx_nxt.sh    = c_r.tx_byte[6:0];
        end else begin
            tx_nxt.bit_v = tx_r.sh[6];
            tx_nxt.sh    = {tx_r.sh[5:0], 1'b0};
        end
    end

    always_ff @(posedge sclk_i or negedge frame_rst_b) begin
        if (!frame_rst_b) begin
            frm_r <= '0;
        end else begin
            frm_r <= frm_nxt;
        end
    end

    // toggle survives deselect so the core never sees a false byte
    always_ff @(posedge sclk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            rxb_r <= '0;
        end else begin
            rxb_r <= rxb_nxt;
        end
    end

    always_ff @(negedge sclk_i or negedge frame_rst_b) begin
        if (!frame_rst_b) begin
            tx_r <= '0;
        end else begin
            tx_r <= tx_nxt;
        end
    end

    // ************************************************************
    // core side
    // ************************************************************
    logic        byte_evt;
    logic [7:0]  rx;
    logic [7:0]  status;
    logic [7:0]  crc_n;
    logic [23:0] acc_n;
    logic [23:0] rval;
    logic [31:0] word;
    logic [2:0]  nb;
    logic        app;
    logic        watch;
    logic        commit;
    logic        pend_set;
    logic        cks_set;
    logic        cks_clr;

    always_comb begin
        c_nxt    = c_r;
        commit   = 1'b0;
        pend_set = 1'b0;
        cks_set  = 1'b0;
        cks_clr  = 1'b0;
        word     = 32'h0000_0000;
        rval     = 24'h00_0000;
        app      = c_r.regs[IDX_IF_MODE][IFM_APPEND_BIT];
        watch    = c_r.regs[IDX_IF_MODE][IFM_WATCH_BIT];
        status   = {c_r.pending, c_r.range_fault, c_r.cks_fault,
                    c_r.integ_fault, 1'b0, c_r.chan};
        rx       = rxb_r.data;
        crc_n    = crc8(c_r.crc, rx);
        acc_n    = {c_r.acc[15:0], rx};
        nb       = reg_bytes(rx[5:0], app);

        c_nxt.cs_s1    = cs_b_i;
        c_nxt.cs_s2    = c_r.cs_s1;
        c_nxt.tgl_s1   = rxb_r.tgl;
        c_nxt.tgl_s2   = c_r.tgl_s1;
        c_nxt.tgl_seen = c_r.tgl_s2;
        c_nxt.txb_s1   = tx_r.bit_v;
        c_nxt.txb_s2   = c_r.txb_s1;
        byte_evt       = c_r.tgl_s2 != c_r.tgl_seen;

        // read value of the index in the incoming command
        if (rx[5:0] == IDX_STATUS) begin
            rval = {16'h0000, status};
        end else if (rx[5:0] == IDX_ID) begin
            rval = {8'h00, ID_VALUE};
        end else if (rx[5:0] == IDX_REG_CHECK) begin
            rval = c_r.sig;
        end else begin
            rval = c_r.regs[rx[5:0]];
        end
        unique case (nb)
            3'h1:    word = {rval[7:0], 24'h00_0000};
            3'h2:    word = {rval[15:0], 16'h0000};
            3'h3:    word = {rval, 8'h00};
            default: word = {c_r.regs[IDX_DATA], status};
        endcase

        if (byte_evt) begin
            unique case (c_r.state)
                ST_IDLE: begin
                    if (!rx[CMD_START_BIT]) begin
                        c_nxt.idx    = rx[5:0];
                        c_nxt.cnt    = nb;
                        c_nxt.crc    = crc8(CRC_INIT, rx);
                        c_nxt.crc_en = c_r.regs[IDX_IF_MODE][IFM_CKS_EN_BIT];
                        c_nxt.acc    = 24'h00_0000;
                        if (rx[CMD_RNW_BIT]) begin
                            c_nxt.state   = ST_READ;
                            c_nxt.tx_byte = word[31:24];
                            c_nxt.rd_word = word[23:0];
                        end else begin
                            c_nxt.state = ST_WRITE;
                        end
                    end
                end
                ST_WRITE: begin
                    c_nxt.acc = acc_n;
                    c_nxt.crc = crc_n;
                    c_nxt.cnt = c_r.cnt - 3'h1;
                    if (c_r.cnt == 3'h1) begin
                        if (c_r.crc_en) begin
                            c_nxt.state = ST_WCRC;
                        end else begin
                            commit      = 1'b1;
                            c_nxt.state = ST_IDLE;
                        end
                    end
                end
                ST_WCRC: begin
                    if (rx == c_r.crc) begin
                        commit = 1'b1;
                    end else begin
                        cks_set = 1'b1;
                    end
                    c_nxt.state = ST_IDLE;
                end
                ST_READ: begin
                    c_nxt.crc = crc8(c_r.crc, c_r.tx_byte);
                    if (c_r.cnt > 3'h1) begin
                        c_nxt.tx_byte = c_r.rd_word[23:16];
                        c_nxt.rd_word = {c_r.rd_word[15:0], 8'h00};
                        c_nxt.cnt     = c_r.cnt - 3'h1;
                    end else if (c_r.cnt == 3'h1 && c_r.crc_en) begin
                        // trailing checksum for the host to verify
                        c_nxt.tx_byte = crc8(c_r.crc, c_r.tx_byte);
                        c_nxt.cnt     = 3'h0;
                    end else begin
                        c_nxt.state   = ST_IDLE;
                        c_nxt.tx_byte = 8'h00;
                        pend_set      = c_r.idx == IDX_DATA;
                        cks_clr       = c_r.idx == IDX_STATUS;
                    end
                end
                default: c_nxt.state = ST_IDLE;
            endcase
        end

        // write data lands only when complete and, with checksums enabled, checked
        if (commit && writable(c_r.idx)) begin
            c_nxt.regs[c_r.idx] = (c_r.state == ST_WCRC) ? c_r.acc : acc_n;
        end

        // abort on deselect
        if (c_r.cs_s2) begin
            c_nxt.state   = ST_IDLE;
            c_nxt.tx_byte = 8'h00;
        end

        // results from the conversion engine win over the data-read set
        if (pend_set) begin
            c_nxt.pending = 1'b1;
        end
        if (result_i.valid) begin
            c_nxt.pending     = 1'b0;
            c_nxt.chan        = result_i.chan;
            c_nxt.range_fault = result_i.over | result_i.under;
            if (result_i.over) begin
                c_nxt.regs[IDX_DATA] = CLAMP_HI;
            end else if (result_i.under) begin
                c_nxt.regs[IDX_DATA] = CLAMP_LO;
            end else begin
                c_nxt.regs[IDX_DATA] = result_i.value;
            end
        end
        if (result_i.calib_done) begin
            c_nxt.pending = 1'b0;
        end
        if (cks_clr) begin
            c_nxt.cks_fault = 1'b0;
        end
        if (cks_set) begin
            c_nxt.cks_fault = 1'b1;
        end

        // configuration integrity watch
        c_nxt.watch_d = watch;
        if (!watch) begin
            c_nxt.integ_fault = 1'b0;
        end else if (!c_r.watch_d) begin
            c_nxt.sig = fold(c_r.regs);
        end else if (fold(c_r.regs) != c_r.sig) begin
            c_nxt.integ_fault = 1'b1;
        end

        c_nxt.sdo    = (c_r.state == ST_READ) ? c_r.txb_s2 : c_r.pending;
        c_nxt.sdo_oe = ~c_r.cs_s2;
    end

    always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            c_r        <= CORE_RST;
            adc_mode_o <= RST_ADC_MODE[15:0];
        end else begin
            c_r        <= c_nxt;
            adc_mode_o <= c_nxt.regs[IDX_ADC_MODE][15:0];
        end
    end

    assign sdo_o    = c_r.sdo;
    assign sdo_oe_o = c_r.sdo_oe;

endmodule

/* File: shared/acsf_pkg.sv */
// shared constants and types of the command and status front end
package acsf_pkg;

    // ************************************************************
    // command byte layout
    // ************************************************************
    localparam int CMD_START_BIT = 7;
    localparam int CMD_RNW_BIT   = 6;
    localparam int IDX_W         = 6;

    // ************************************************************
    // register indices and banks
    // ************************************************************
    localparam logic [5:0] IDX_STATUS    = 6'h00;
    localparam logic [5:0] IDX_ADC_MODE  = 6'h01;
    localparam logic [5:0] IDX_IF_MODE   = 6'h02;
    localparam logic [5:0] IDX_REG_CHECK = 6'h03;
    localparam logic [5:0] IDX_DATA      = 6'h04;
    localparam logic [5:0] IDX_GPIO      = 6'h06;
    localparam logic [5:0] IDX_ID        = 6'h07;
    localparam logic [2:0] BANK_CHANNEL  = 3'h2;
    localparam logic [2:0] BANK_SETUP    = 3'h4;
    localparam logic [2:0] BANK_FILTER   = 3'h5;
    localparam logic [2:0] BANK_OFFSET   = 3'h6;
    localparam logic [2:0] BANK_GAIN     = 3'h7;

    // ************************************************************
    // status and interface mode fields
    // ************************************************************
    localparam int         ST_PENDING_BIT = 7;
    localparam int         ST_RANGE_BIT   = 6;
    localparam int         ST_CKS_BIT     = 5;
    localparam int         ST_INTEG_BIT   = 4;
    localparam logic [7:0] STATUS_RESET   = 8'h80;
    localparam int         IFM_APPEND_BIT = 6;
    localparam int         IFM_CKS_EN_BIT = 2;
    localparam int         IFM_WATCH_BIT  = 0;

    // ************************************************************
    // reset values, clamps, checksum
    // ************************************************************
    localparam logic [23:0] RST_ADC_MODE = 24'h00_2000;
    localparam logic [23:0] RST_SETUP    = 24'h00_1000;
    localparam logic [23:0] RST_FILTER   = 24'h00_0500;
    localparam logic [23:0] RST_OFFSET   = 24'h80_0000;
    localparam logic [23:0] CLAMP_HI     = 24'hFF_FFFF;
    localparam logic [23:0] CLAMP_LO     = 24'h00_0000;
    localparam logic [7:0]  CRC_POLY     = 8'h07;
    localparam logic [7:0]  CRC_INIT     = 8'h00;
    localparam logic [2:0]  LAST_BIT     = 3'h7;

    typedef enum logic [1:0] {
        ST_IDLE,
        ST_WRITE,
        ST_WCRC,
        ST_READ
    } acsf_state_t;

    // conversion engine result, one-cycle valid
    typedef struct packed {
        logic        valid;
        logic        calib_done;
        logic        over;
        logic        under;
        logic [2:0]  chan;
        logic [23:0] value;
    } acsf_result_t;

endpackage

/* File: tb/acsf_front_end_properties.sv */
// port assertions for the command and status front end
`timescale 1ns/1ps
module acsf_front_end_properties
    import acsf_pkg::*;
(
    input wire logic         ref_clk_i,
    input wire logic         rst_b_i,
    input wire logic         sclk_i,
    input wire logic         cs_b_i,
    input wire logic         sdi_i,
    input wire acsf_result_t result_i,
    input wire logic         sdo_o,
    input wire logic         sdo_oe_o,
    input wire logic [15:0]  adc_mode_o
);
    // ************************************************************
    // helper counters
    // ************************************************************
    logic [4:0] quiet_r;
    logic [3:0] rise_r;
    logic       sclk_r;
    logic       evt_r;
    logic       quiet;

    // quiet: selected, clock parked high longer than half a link period
    assign quiet = (quiet_r >= 5'h10);

    always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            quiet_r <= 5'h0;
            rise_r  <= 4'hF;
            sclk_r  <= 1'b1;
            evt_r   <= 1'b0;
        end else begin
            sclk_r <= sclk_i;
            if (cs_b_i || !sclk_i || !sclk_r) begin
                quiet_r <= 5'h0;
            end else if (quiet_r != 5'h1F) begin
                quiet_r <= quiet_r + 5'h1;
            end
            if (sclk_i && !sclk_r) begin
                rise_r <= 4'h0;
            end else if (rise_r != 4'hF) begin
                rise_r <= rise_r + 4'h1;
            end
            if (result_i.valid || result_i.calib_done) begin
                evt_r <= 1'b1;
            end
        end
    end

    // ************************************************************
    // properties
    // ************************************************************
    default clocking cb @(posedge ref_clk_i);
    endclocking
    default disable iff (!rst_b_i);

    sequence s_selected;
        (!cs_b_i)[*5];
    endsequence
    sequence s_new_result;
        quiet && result_i.valid;
    endsequence
    sequence s_ready_low;
        ##2 !sdo_o;
    endsequence

    a_oe_on_select: assert property (s_selected |-> sdo_oe_o)
        else $error("data out not driven while selected");
    a_oe_off_idle: assert property (cs_b_i[*5] |-> !sdo_oe_o)
        else $error("data out driven while deselected");
    a_result_ready: assert property (s_new_result |-> s_ready_low)
        else $error("ready line not low after a result");
    a_calib_ready: assert property (quiet && result_i.calib_done |-> s_ready_low)
        else $error("ready line not low after calibration");
    a_ready_holds_high: assert property (quiet && sdo_o && !result_i.valid
        && !result_i.calib_done && !$past(result_i.valid) && !$past(result_i.calib_done)
        |=> sdo_o) else $error("ready line fell without a result");
    a_ready_holds_low: assert property (quiet && !sdo_o |=> !sdo_o)
        else $error("ready line rose without a data read");
    a_ready_at_reset: assert property (quiet && !evt_r |-> sdo_o)
        else $error("ready line low before any result");
    a_mode_by_write: assert property ($changed(adc_mode_o) |-> rise_r < 4'hC)
        else $error("mode output changed away from a write");
endmodule

bind acsf_front_end acsf_front_end_properties u_props (
    .ref_clk_i  (ref_clk_i),
    .rst_b_i    (rst_b_i),
    .sclk_i     (sclk_i),
    .cs_b_i     (cs_b_i),
    .sdi_i      (sdi_i),
    .result_i   (result_i),
    .sdo_o      (sdo_o),
    .sdo_oe_o   (sdo_oe_o),
    .adc_mode_o (adc_mode_o)
);

/* File: tb/acsf_front_end_tb.sv */
// self-checking bench for the command and status front end
`timescale 1ns/1ps
module acsf_front_end_tb;
    import acsf_pkg::*;
    localparam logic [15:0] ID_TEST   = 16'h3C69;  // arbitrary value
    localparam logic [23:0] GAIN_TEST = 24'h55_AA00;
    typedef struct packed {
        logic [5:0]  idx;
        logic [1:0]  nb;
        logic        chk;
        logic [23:0] rst;
        logic [23:0] wval;
        logic [23:0] exp;
    } acsf_row_t;

    logic         ref_clk;
    logic         rst_b;
    logic         sclk;
    logic         cs_b;
    logic         sdi;
    logic         sdo;
    logic         sdo_oe;
    logic [15:0]  adc_mode;
    acsf_result_t res;
    int           fails;
    int           check_count;
    bit           crc_on;
    logic [31:0]  v;
    logic [47:0]  rx;
    acsf_row_t    rows [14];

    acsf_front_end #(.ID_VALUE(ID_TEST), .GAIN_RESET(GAIN_TEST)) uut (
        .ref_clk_i  (ref_clk),
        .rst_b_i    (rst_b),
        .sclk_i     (sclk),
        .cs_b_i     (cs_b),
        .sdi_i      (sdi),
        .result_i   (res),
        .sdo_o      (sdo),
        .sdo_oe_o   (sdo_oe),
        .adc_mode_o (adc_mode)
    );
    acsf_host_model host (
        .sclk_o   (sclk),
        .cs_b_o   (cs_b),
        .sdi_o    (sdi),
        .sdo_i    (sdo),
        .sdo_oe_i (sdo_oe)
    );

    always #2.5 ref_clk = ~ref_clk;

    // ************************************************************
    // tasks
    // ************************************************************
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        check_count++;
        if (seen !== exp) begin
            fails++;
            $display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask

    function automatic logic [7:0] crc8(input logic [47:0] d, input int nbits);
        logic [7:0] c;
        c = CRC_INIT;
        for (int i = nbits - 1; i >= 0; i--) begin
            c = {c[6:0], 1'b0} ^ ((c[7] ^ d[i]) ? CRC_POLY : 8'h00);
        end
        return c;
    endfunction

    task automatic rd(input logic [5:0] idx, input int nb, output logic [31:0] val);
        logic [47:0] r;
        logic [7:0]  c;
        int          k;
        c = {2'b01, idx};
        k = crc_on ? nb + 1 : nb;
        host.xfer(48'(c) << (8 * k), k + 1, r);
        r = r & ~(48'hFFFF_FFFF_FFFF << (8 * k));
        if (crc_on) begin
            check(32'(r[7:0]), 32'(crc8((48'(c) << (8 * nb)) | (r >> 8), 8 * nb + 8)));
            r = r >> 8;
        end
        val = r[31:0];
    endtask

    task automatic wr(input logic [5:0] idx, input int nb, input logic [23:0] val,
                      input logic bad);
        logic [47:0] d;
        logic [47:0] r;
        int          k;
        d = (48'({2'b00, idx}) << (8 * nb)) | 48'(val);
        k = nb + 1;
        if (crc_on) begin
            d = (d << 8) | 48'(crc8(d, 8 * k) ^ {7'h0, bad});
            k = k + 1;
        end
        host.xfer(d, k, r);
    endtask

    // result pulse while the host holds the port selected and idle
    task automatic pulse(input acsf_result_t r);
        fork
            host.park(400);
            begin
                repeat (30) @(negedge ref_clk);
                res = r;
                @(negedge ref_clk);
                res = '0;
            end
        join
    endtask

    task automatic results();
        $display("checks %0d mismatches %0d", check_count, fails);
        if (fails == 0 && check_count > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask

    initial begin
        #400_000;
        fails++;
        results();
    end

    // ************************************************************
    // main sequence
    // ************************************************************
    initial begin
        ref_clk = 1'b0;
        rst_b = 1'b0;
        res = '0;
        fails = 0;
        check_count = 0;
        crc_on = 1'b0;
        rows = '{
            '{6'h00, 2'h1, 1'b1, 24'h00_0080, 24'h00_00FF, 24'h00_0080},
            '{6'h01, 2'h2, 1'b1, 24'h00_2000, 24'h00_0010, 24'h00_0010},
            '{6'h07, 2'h2, 1'b1, 24'(ID_TEST), 24'h00_1234, 24'(ID_TEST)},
            '{6'h10, 2'h2, 1'b0, 24'h00_0000, 24'h00_1111, 24'h00_1111},
            '{6'h17, 2'h2, 1'b0, 24'h00_0000, 24'h00_1717, 24'h00_1717},
            '{6'h20, 2'h2, 1'b1, RST_SETUP, 24'h00_2020, 24'h00_2020},
            '{6'h27, 2'h2, 1'b1, RST_SETUP, 24'h00_2727, 24'h00_2727},
            '{6'h28, 2'h2, 1'b1, RST_FILTER, 24'h00_2828, 24'h00_2828},
            '{6'h2F, 2'h2, 1'b1, RST_FILTER, 24'h00_2F2F, 24'h00_2F2F},
            '{6'h30, 2'h3, 1'b1, RST_OFFSET, 24'h30_3030, 24'h30_3030},
            '{6'h37, 2'h3, 1'b1, RST_OFFSET, 24'h37_3737, 24'h37_3737},
            '{6'h38, 2'h3, 1'b1, GAIN_TEST, 24'h38_3838, 24'h38_3838},
            '{6'h3F, 2'h3, 1'b1, GAIN_TEST, 24'h3F_3F3F, 24'h3F_3F3F}
            , '{6'h06, 2'h2, 1'b1, 24'h00_0000, 24'h00_0606, 24'h00_0606}
        };
        repeat (6) @(negedge ref_clk);
        rst_b = 1'b1;
        repeat (4) @(negedge ref_clk);
        #3.3;
        check(32'(adc_mode), 32'h2000);
        host.park(400);
        for (int i = 0; i < 14; i++) begin
            rd(rows[i].idx, rows[i].nb, v);
            if (rows[i].chk) check(v, 32'(rows[i].rst));
            wr(rows[i].idx, rows[i].nb, rows[i].wval, 1'b0);
        end
        for (int i = 0; i < 14; i++) begin
            rd(rows[i].idx, rows[i].nb, v);
            check(v, 32'(rows[i].exp));
        end
        check(32'(adc_mode), 32'h0010);
        pulse({2'b10, 2'b00, 3'h5, 24'h12_3456});
        rd(IDX_STATUS, 1, v);
        check(v, 32'h05);
        rd(IDX_DATA, 3, v);
        check(v, 32'h0012_3456);
        rd(IDX_STATUS, 1, v);
        check(v, 32'h85);
        pulse({2'b01, 2'b00, 3'h0, 24'h00_0000});
        rd(IDX_STATUS, 1, v);
        check(v, 32'h05);
        pulse({2'b10, 2'b10, 3'h7, 24'h00_0123});
        rd(IDX_DATA, 3, v);
        check(v, 32'h00FF_FFFF);
        pulse({2'b01, 2'b00, 3'h0, 24'h00_0000});
        rd(IDX_STATUS, 1, v);
        check(v, 32'h47);
        pulse({2'b10, 2'b01, 3'h2, 24'h00_F000});
        rd(IDX_DATA, 3, v);
        check(v, 32'h0000_0000);
        rd(IDX_STATUS, 1, v);
        check(v, 32'hC2);
        pulse({2'b10, 2'b00, 3'h3, 24'h00_ABCD});
        wr(IDX_IF_MODE, 2, 24'h00_0040, 1'b0);
        rd(IDX_DATA, 4, v);
        check(v, 32'h00AB_CD03);
        wr(IDX_IF_MODE, 2, 24'h00_0000, 1'b0);
        host.xfer(48'h00C2_4000, 3, rx);
        check(32'(rx[7:0]), 32'h83);
        host.xfer(48'h0000_0133, 2, rx);
        rd(IDX_ADC_MODE, 2, v);
        check(v, 32'h0010);
        wr(IDX_IF_MODE, 2, 24'h00_0004, 1'b0);
        crc_on = 1'b1;
        wr(IDX_ADC_MODE, 2, 24'h00_0020, 1'b1);
        check(32'(adc_mode), 32'h0010);
        rd(IDX_STATUS, 1, v);
        check(v, 32'hA3);
        rd(IDX_STATUS, 1, v);
        check(v, 32'h83);
        wr(IDX_ADC_MODE, 2, 24'h00_0020, 1'b0);
        check(32'(adc_mode), 32'h0020);
        wr(IDX_IF_MODE, 2, 24'h00_0001, 1'b0);
        crc_on = 1'b0;
        wr(6'h10, 2, 24'h00_5555, 1'b0);
        rd(IDX_STATUS, 1, v);
        check(v, 32'h93);
        rd(IDX_STATUS, 1, v);
        check(v, 32'h93);
        wr(IDX_IF_MODE, 2, 24'h00_0000, 1'b0);
        rd(IDX_STATUS, 1, v);
        check(v, 32'h83);
        results();
    end
endmodule

/* File: tb/acsf_host_model.sv */
// serial host clocking bytes into the front end, clock idle high
`timescale 1ns/1ps
module acsf_host_model (
    output logic      sclk_o,
    output logic      cs_b_o,
    output logic      sdi_o,
    input  wire logic sdo_i,
    input  wire logic sdo_oe_i
);
    localparam realtime HALF = 62.5;

    initial begin
        sclk_o = 1'b1;
        cs_b_o = 1'b1;
        sdi_o  = 1'b0;
    end

    // data line toggles between frames
    always #(HALF) begin
        if (cs_b_o) begin
            sdi_o = ~sdi_o;
        end
    end

    task automatic xfer(input logic [47:0] tx, input int nb, output logic [47:0] rx);
        rx = '0;
        cs_b_o = 1'b0;
        #(HALF);
        for (int i = 8 * nb - 1; i >= 0; i--) begin
            sclk_o = 1'b0;
            sdi_o  = tx[i];
            #(HALF);
            sclk_o = 1'b1;
            rx[i]  = sdo_oe_i ? sdo_i : ~sdo_i;
            #(HALF);
        end
        cs_b_o = 1'b1;
        #(4 * HALF);
    endtask

    task automatic park(input int ns);
        cs_b_o = 1'b0;
        #(ns);
        cs_b_o = 1'b1;
        #(2 * HALF);
    endtask
endmodule
